// [shared/meter_assist_cfg.svh]
// Offsets, field positions, reset values and timing counts for the meter assist block
`ifndef METER_ASSIST_CFG_SVH
`define METER_ASSIST_CFG_SVH

// Configuration RAM location of the accumulation length register
`define ACC_LEN_ADDR 16'h2001
`define ACC_LEN_RST 8'hFF
// Field positions inside accumulation_length
`define FIRST_STAGE_MSB 7
`define FIRST_STAGE_LSB 6
`define SECOND_STAGE_MSB 5
`define SECOND_STAGE_LSB 0

// One pulse_spacing count is worth this many filter clocks
`define SPACING_TICKS 4
// pulse_width_limit value that turns width checking off
`define WIDTH_NO_CHECK 8'hFF

// Monitor serial format
`define MON_WORDS 4
`define MON_WORD_BITS 32
`define MON_SLOT_BITS 35
// System clocks per half period of test_clock
`define TEST_CLK_HALF 2

// Highest equation_select value served
`define EQU_MAX 3'h5

`endif

// [shared/meter_assist_pkg.sv]
// Types shared by the meter assist block
package meter_assist_pkg;

  // Energy pulse sign pair as exported by the engine
  typedef struct packed {
    logic real_e;
    logic reactive_e;
  } pulse_pair_t;

  // One set of voltage and current samples
  typedef struct packed {
    logic signed [15:0] va;
    logic signed [15:0] ia;
    logic signed [15:0] vb;
    logic signed [15:0] ib;
    logic signed [15:0] vc;
    logic signed [15:0] ic;
  } samples_t;

  // Element products handed back to the engine
  typedef struct packed {
    logic signed [31:0] e0;
    logic signed [31:0] e1;
    logic signed [31:0] e2;
  } elements_t;

  // The four monitored data-RAM words, word 0 in the top bits
  typedef logic [127:0] mon_words_t;

endpackage

// [core/pulse_fifo.sv]
// Small synchronous FIFO with flush, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module pulse_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("pulse_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage
  logic [AW:0] wr_ptr_reg;            // Extra bit tells full from empty
  logic [AW:0] rd_ptr_reg;
  logic do_wr;
  logic do_rd;

  assign in_ready_o = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
  assign do_wr = in_valid_i && in_ready_o && !flush_i;
  assign do_rd = out_valid_o && out_ready_i && !flush_i;
  // Head entry read through; the consumer registers it
  assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];

  // Pointers; flush drops everything queued
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || flush_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_rd)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Storage needs no reset
  always_ff @(posedge sys_clk_i)
  begin
    if (do_wr)
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
  end

endmodule

`default_nettype wire

// [core/monitor_shifter.sv]
// Serialiser for the live word monitor, with its own test clock
`timescale 1ns/1ps
`default_nettype none

module monitor_shifter #(
  parameter int WORDS = 4,
  parameter int WORD_W = 32,
  parameter int SLOT_W = 35,
  parameter int HALF = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic enable_i,
  input wire logic start_i,
  input wire logic [WORDS*WORD_W-1:0] words_i,
  // Serial side
  output logic ser_o,
  output logic sclk_o,
  output logic busy_o
);

  localparam int TOTAL = WORDS * SLOT_W;
  localparam int CW = $clog2(TOTAL + 1);
  localparam int DW = $clog2(HALF * 2 + 1);

  initial
  begin
    if (SLOT_W < WORD_W + 1 || HALF < 1)
      $error("monitor_shifter: slot must hold flag and word");
  end

  logic [TOTAL-1:0] frame;        // Flag, word, trailing zeros per slot
  logic [TOTAL-1:0] shift_reg;
  logic [CW-1:0] bits_left_reg;
  logic [DW-1:0] div_reg;

  // Each slot: leading flag high, word MSB first, then low padding
  genvar g;
  generate
    for (g = 0; g < WORDS; g++)
    begin : g_slot
      assign frame[TOTAL-1-g*SLOT_W -: SLOT_W] =
        {1'b1, words_i[(WORDS-g)*WORD_W-1 -: WORD_W], (SLOT_W-WORD_W-1)'(0)};
    end
  endgenerate

  assign busy_o = bits_left_reg != '0;

  // Load at pass start, one bit per test clock period
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || !enable_i)
    begin
      // Dropping enable ends the output at once
      shift_reg <= '0;
      bits_left_reg <= '0;
      div_reg <= '0;
    end
    else if (start_i)
    begin
      shift_reg <= frame;
      bits_left_reg <= CW'(TOTAL);
      div_reg <= '0;
    end
    else if (busy_o)
    begin
      if (div_reg == DW'(2*HALF-1))
      begin
        div_reg <= '0;
        shift_reg <= {shift_reg[TOTAL-2:0], 1'b0};
        bits_left_reg <= bits_left_reg - 1'b1;
      end
      else
        div_reg <= div_reg + 1'b1;
    end
  end

  // Data changes on the falling test clock edge, low when idle
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ser_o <= 1'b0;
      sclk_o <= 1'b0;
    end
    else
    begin
      ser_o <= busy_o && enable_i && !start_i && shift_reg[TOTAL-1];
      sclk_o <= busy_o && enable_i && !start_i && (div_reg >= DW'(HALF));
    end
  end

endmodule

`default_nettype wire

// [core/meter_assist.sv]
// Equation, monitor, pulse and accumulation assist beside the compute engine
`timescale 1ns/1ps
`default_nettype none
`include "meter_assist_cfg.svh"
module meter_assist #(
  parameter int FIFO_DEPTH = 8,
  parameter int TEST_HALF = `TEST_CLK_HALF
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Configuration RAM port
  input wire logic [15:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // Loose control settings
  input wire logic [2:0] equation_select_i,
  input wire logic monitor_enable_i,
  input wire logic pulse_polarity_invert_i,
  input wire logic [7:0] pulse_spacing_i,
  input wire logic [7:0] pulse_width_limit_i,
  input wire logic [1:0] optical_tx_source_select_i,
  // Engine and multiplexer side
  input wire logic frame_sync_i,
  input wire logic sample_strobe_i,
  input wire meter_assist_pkg::samples_t samples_i,
  input wire meter_assist_pkg::mon_words_t mon_words_i,
  input wire logic pulse_valid_i,
  input wire meter_assist_pkg::pulse_pair_t pulse_bits_i,
  output logic pulse_ready_o,
  input wire logic extra_valid_i,
  input wire meter_assist_pkg::pulse_pair_t extra_bits_i,
  output meter_assist_pkg::elements_t elements_o,
  // Monitor pins
  output logic test_mux_output_o,
  output logic test_clock_o,
  // Pulse pins
  output logic general_io_6_o,
  output logic general_io_7_o,
  output logic general_io_8_o,
  output logic general_io_9_o,
  output logic optical_transmit_o,
  // Interrupt strobes to the microcontroller
  output logic frame_done_irq_o,
  output logic transfer_ready_irq_o
);
  initial
  begin
    if (FIFO_DEPTH < 2 || TEST_HALF < 1)
      $error("meter_assist: bad FIFO_DEPTH or TEST_HALF");
  end
  localparam logic [9:0] TICKS = 10'(`SPACING_TICKS);
  logic frame_sync_q_reg;   // Previous frame_sync level
  logic frame_start;        // One cycle on the rising edge
  assign frame_start = frame_sync_i && !frame_sync_q_reg;
  // Edge detector history
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      frame_sync_q_reg <= 1'b0;
    else
      frame_sync_q_reg <= frame_sync_i;
  end
  // Accumulation length register, the only mapped location
  logic [7:0] acc_len_reg;
  // Software write port
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      acc_len_reg <= `ACC_LEN_RST;
    else if (cfg_wr_i && cfg_addr_i == `ACC_LEN_ADDR)
      acc_len_reg <= cfg_wdata_i;
  end
  // Read data registered; other addresses read zero
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      cfg_rdata_o <= 8'h00;
    else if (cfg_addr_i == `ACC_LEN_ADDR)
      cfg_rdata_o <= acc_len_reg;
    else
      cfg_rdata_o <= 8'h00;
  end
  // Equation assist: halved difference keeps the product inside 32 bits
  function automatic logic signed [15:0] half_diff(input logic signed [15:0] a,
                                                   input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    return d[16:1];
  endfunction
  // Products updated on every sample
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      elements_o <= '0;
    else if (sample_strobe_i)
    begin
      // Unused elements read zero; each branch fills only what it uses
      elements_o <= '0;
      case (equation_select_i)
        3'h0:
        begin
          elements_o.e0 <= samples_i.va * samples_i.ia;
          elements_o.e1 <= samples_i.va * samples_i.ib;
        end
        3'h1:
          elements_o.e0 <= samples_i.va * half_diff(samples_i.ia, samples_i.ib);
        3'h2:
        begin
          elements_o.e0 <= samples_i.va * samples_i.ia;
          elements_o.e1 <= samples_i.vb * samples_i.ib;
        end
        3'h3:
        begin
          elements_o.e0 <= samples_i.va * half_diff(samples_i.ia, samples_i.ib);
          elements_o.e1 <= samples_i.vc * samples_i.ic;
        end
        3'h4:
        begin
          elements_o.e0 <= samples_i.va * half_diff(samples_i.ia, samples_i.ib);
          elements_o.e1 <= samples_i.vb * half_diff(samples_i.ic, samples_i.ib);
        end
        `EQU_MAX:
        begin
          elements_o.e0 <= samples_i.va * samples_i.ia;
          elements_o.e1 <= samples_i.vb * samples_i.ib;
          elements_o.e2 <= samples_i.vc * samples_i.ic;
        end
        // Values above 5 produce nothing
        default:
          elements_o <= '0;
      endcase
    end
  end
  // Live word monitor, started at the head of every pass
  monitor_shifter #(
    .WORDS(`MON_WORDS),
    .WORD_W(`MON_WORD_BITS),
    .SLOT_W(`MON_SLOT_BITS),
    .HALF(TEST_HALF)
  ) u_monitor (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(monitor_enable_i),
    .start_i(frame_start),
    .words_i(mon_words_i),
    .ser_o(test_mux_output_o),
    .sclk_o(test_clock_o),
    .busy_o()
  );
  // Energy pulse queue
  logic fifo_out_valid;
  meter_assist_pkg::pulse_pair_t fifo_out_data;
  logic pop;                    // Take head entry this cycle
  logic bypass;                 // Zero spacing skips the queue
  logic [9:0] gap_cnt_reg;      // Filter clocks until next release
  logic [9:0] gap_load;
  logic update;                 // An energy pulse update is applied
  meter_assist_pkg::pulse_pair_t update_bits;
  logic fifo_in_ready;          // Queue has room for one more update
  assign bypass = pulse_spacing_i == 8'h00;
  assign gap_load = 10'(pulse_spacing_i) * TICKS;
  pulse_fifo #(
    .WIDTH(2),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(frame_start || bypass),
    .in_valid_i(pulse_valid_i && !bypass),
    .in_data_i(pulse_bits_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(pop)
  );
  // Engine is stalled only when the queue is full
  assign pulse_ready_o = bypass || fifo_in_ready;
  assign pop = !bypass && fifo_out_valid && gap_cnt_reg == 10'd0 && !frame_start;
  assign update = bypass ? pulse_valid_i : pop;
  assign update_bits = bypass ? pulse_bits_i : fifo_out_data;
  // Interval counter: first delay from frame start, then gap after each pop
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      gap_cnt_reg <= 10'd0;
    else if (frame_start || pop)
      gap_cnt_reg <= gap_load - 10'd1;
    else if (gap_cnt_reg != 10'd0)
      gap_cnt_reg <= gap_cnt_reg - 10'd1;
  end
  // Width limiter, one lane each for real and reactive
  logic [8:0] nmax;             // 2*limit+1 updates
  logic no_check;
  logic [1:0] raw_bits;
  logic [1:0] pulse_state_reg;  // Active-true internal pulse levels
  logic [8:0] run_cnt_reg [2];  // Consecutive active updates
  assign nmax = {pulse_width_limit_i, 1'b1};
  assign no_check = pulse_width_limit_i == `WIDTH_NO_CHECK;
  assign raw_bits = {update_bits.real_e, update_bits.reactive_e};
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++)
    begin : g_lane
      // Runs are counted in updates, not in clocks
      always_ff @(posedge sys_clk_i)
      begin
        if (!rst_n_i)
        begin
          run_cnt_reg[lane] <= 9'd0;
          pulse_state_reg[lane] <= 1'b0;
        end
        else if (update)
        begin
          if (!raw_bits[lane])
          begin
            // Inactive update restarts the run
            run_cnt_reg[lane] <= 9'd0;
            pulse_state_reg[lane] <= 1'b0;
          end
          else if (!no_check && run_cnt_reg[lane] >= nmax)
            pulse_state_reg[lane] <= 1'b0;
          else
          begin
            run_cnt_reg[lane] <= run_cnt_reg[lane] + 9'd1;
            pulse_state_reg[lane] <= 1'b1;
          end
        end
      end
    end
  endgenerate
  // Extra pulses, latched once per pass
  logic [1:0] extra_reg;
  // Engine writes both bits together
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      extra_reg <= 2'b00;
    else if (extra_valid_i)
      extra_reg <= {extra_bits_i.real_e, extra_bits_i.reactive_e};
  end
  // Pin levels: active low unless inverted
  logic inactive_lvl;
  logic [3:0] pin_lvl;
  assign inactive_lvl = !pulse_polarity_invert_i;
  assign pin_lvl = {extra_reg, pulse_state_reg} ^ {4{inactive_lvl}};
  // Registered pin drivers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      general_io_6_o <= 1'b1;
      general_io_7_o <= 1'b1;
      general_io_8_o <= 1'b1;
      general_io_9_o <= 1'b1;
      optical_transmit_o <= 1'b1;
    end
    else
    begin
      general_io_6_o <= pin_lvl[1];
      general_io_7_o <= pin_lvl[0];
      general_io_8_o <= pin_lvl[3];
      general_io_9_o <= pin_lvl[2];
      case (optical_tx_source_select_i)
        2'h1: optical_transmit_o <= pin_lvl[1];
        2'h2: optical_transmit_o <= pin_lvl[0];
        // Unused selections park at the inactive level
        default: optical_transmit_o <= inactive_lvl;
      endcase
    end
  end
  // Two-level accumulation counters
  logic [1:0] first_len;
  logic [5:0] second_len;
  logic [1:0] first_cnt_reg;
  logic [5:0] second_cnt_reg;
  logic first_done;
  logic second_done;
  assign first_len = acc_len_reg[`FIRST_STAGE_MSB:`FIRST_STAGE_LSB];
  assign second_len = acc_len_reg[`SECOND_STAGE_MSB:`SECOND_STAGE_LSB];
  // A zero length behaves as one so the interval always ends
  assign first_done = sample_strobe_i && (first_cnt_reg + 2'd1 >= first_len);
  assign second_done = first_done && (second_cnt_reg + 6'd1 >= second_len);
  // Sample and sum counters
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      first_cnt_reg <= 2'd0;
      second_cnt_reg <= 6'd0;
    end
    else if (first_done)
    begin
      first_cnt_reg <= 2'd0;
      second_cnt_reg <= second_done ? 6'd0 : second_cnt_reg + 6'd1;
    end
    else if (sample_strobe_i)
      first_cnt_reg <= first_cnt_reg + 2'd1;
  end
  // Interrupt strobes, one cycle each
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      frame_done_irq_o <= 1'b0;
      transfer_ready_irq_o <= 1'b0;
    end
    else
    begin
      // A new frame_sync edge closes the previous multiplexer cycle
      frame_done_irq_o <= frame_start;
      transfer_ready_irq_o <= second_done;
    end
  end
endmodule

`default_nettype wire

// [test/meter_assist_chk.sv]
// Concurrent checks on the meter assist block ports
`timescale 1ns/1ps
`default_nettype none
`include "meter_assist_cfg.svh"
module meter_assist_chk (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Configuration port
  input wire logic [15:0] cfg_addr_i,
  input wire logic [7:0] cfg_rdata_o,
  // Settings
  input wire logic monitor_enable_i,
  input wire logic pulse_polarity_invert_i,
  input wire logic [7:0] pulse_spacing_i,
  input wire logic [7:0] pulse_width_limit_i,
  input wire logic [1:0] optical_tx_source_select_i,
  // Engine side
  input wire logic frame_sync_i,
  input wire logic sample_strobe_i,
  input wire logic pulse_valid_i,
  input wire meter_assist_pkg::pulse_pair_t pulse_bits_i,
  input wire logic pulse_ready_o,
  // Pins and strobes
  input wire logic test_mux_output_o,
  input wire logic test_clock_o,
  input wire logic general_io_6_o,
  input wire logic general_io_7_o,
  input wire logic optical_transmit_o,
  input wire logic frame_done_irq_o,
  input wire logic transfer_ready_irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Frame start as the block sees it
  sequence s_frame_rise;
    $rose(frame_sync_i);
  endsequence
  // Accepted update with no queue and no width limit
  sequence s_push_bypass;
    pulse_spacing_i == 8'h00 && pulse_width_limit_i == `WIDTH_NO_CHECK
      && pulse_valid_i && pulse_ready_o;
  endsequence
  AST_MON_OFF: assert property (!monitor_enable_i |=> !test_mux_output_o && !test_clock_o)
    else $error("monitor pins active while disabled");
  AST_FRAME_IRQ: assert property (s_frame_rise |=> frame_done_irq_o)
    else $error("frame interrupt missing after frame start");
  AST_FRAME_CAUSE: assert property (frame_done_irq_o |-> $past(frame_sync_i) && !$past(frame_sync_i, 2))
    else $error("frame interrupt without frame start");
  AST_XFER_CAUSE: assert property (transfer_ready_irq_o |-> $past(sample_strobe_i))
    else $error("transfer interrupt without sample strobe");
  AST_CFG_OTHER: assert property (cfg_addr_i != `ACC_LEN_ADDR |=> cfg_rdata_o == 8'h00)
    else $error("unmapped address read non-zero");
  AST_READY: assert property (!pulse_ready_o |-> pulse_spacing_i != 8'h00)
    else $error("update refused in bypass mode");
  AST_OPT_REAL: assert property (optical_tx_source_select_i == 2'h1 && $past(optical_tx_source_select_i) == 2'h1 |-> optical_transmit_o == general_io_6_o)
    else $error("optical output differs from real pulse pin");
  AST_BYPASS_REAL: assert property (s_push_bypass |-> ##2 general_io_6_o == ($past(pulse_bits_i.real_e, 2) ^ !$past(pulse_polarity_invert_i)))
    else $error("real pulse pin wrong after bypass update");
  AST_BYPASS_REACT: assert property (s_push_bypass |-> ##2 general_io_7_o == ($past(pulse_bits_i.reactive_e, 2) ^ !$past(pulse_polarity_invert_i)))
    else $error("reactive pulse pin wrong after bypass update");
endmodule
bind meter_assist meter_assist_chk meter_assist_chk_inst (.*);
`default_nettype wire

// [test/engine_model.sv]
// Behavioural compute engine and multiplexer timing
`timescale 1ns/1ps
`default_nettype none
module engine_model (
  // Clock
  input wire logic sys_clk_i,
  // Pulse update handshake
  input wire logic pulse_ready_i,
  output logic pulse_valid_o,
  output meter_assist_pkg::pulse_pair_t pulse_bits_o,
  // Frame timing
  output logic frame_sync_o
);
  // Quiet lines at time zero
  initial
  begin
    pulse_valid_o = 1'b0;
    pulse_bits_o = 2'b00;
    frame_sync_o = 1'b0;
  end
  // One-cycle frame mark; the block acts on its rising edge
  task automatic frame();
    @(posedge sys_clk_i);
    #1 frame_sync_o = 1'b1;
    @(posedge sys_clk_i);
    #1 frame_sync_o = 1'b0;
  endtask
  // Offer one update and hold it until an edge sees ready
  task automatic push(input meter_assist_pkg::pulse_pair_t b);
    pulse_bits_o = b;
    pulse_valid_o = 1'b1;
    while (pulse_ready_i !== 1'b1)
    begin
      @(posedge sys_clk_i);
      #1;
    end
    @(posedge sys_clk_i);
    #1;
  endtask
  // Release; stale data flips so nobody can lean on it
  task automatic stop();
    pulse_valid_o = 1'b0;
    pulse_bits_o = ~pulse_bits_o;
  endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking testbench for the meter assist block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Design inputs
  logic sys_clk_i, rst_n_i, cfg_wr_i, monitor_enable_i, pulse_polarity_invert_i;
  logic sample_strobe_i, extra_valid_i, frame_sync_i, pulse_valid_i;
  logic [15:0] cfg_addr_i;
  logic [7:0] cfg_wdata_i, pulse_spacing_i, pulse_width_limit_i;
  logic [2:0] equation_select_i;
  logic [1:0] optical_tx_source_select_i;
  meter_assist_pkg::samples_t samples_i;
  meter_assist_pkg::mon_words_t mon_words_i;
  meter_assist_pkg::pulse_pair_t pulse_bits_i, extra_bits_i;
  // Design outputs
  logic [7:0] cfg_rdata_o;
  logic pulse_ready_o, test_mux_output_o, test_clock_o, general_io_6_o, general_io_7_o;
  logic general_io_8_o, general_io_9_o, optical_transmit_o, frame_done_irq_o, transfer_ready_irq_o;
  meter_assist_pkg::elements_t elements_o;
  // Bookkeeping
  int n_mismatch = 0, n_tests = 0, n_frame = 0, n_xfer = 0;
  logic [139:0] mon_bits;
  // Element products for va=3 ia=6 vb=5 ib=2 vc=4 ic=8
  int e_tab [8][3] = '{'{18, 6, 0}, '{6, 0, 0}, '{18, 10, 0}, '{6, 32, 0}, '{6, 15, 0},
    '{18, 10, 32}, '{0, 0, 0}, '{0, 0, 0}};
  meter_assist #(.FIFO_DEPTH(8), .TEST_HALF(2)) meter_assist_inst (.*);
  engine_model engine_model_inst (.sys_clk_i(sys_clk_i), .pulse_ready_i(pulse_ready_o),
    .pulse_valid_o(pulse_valid_i), .pulse_bits_o(pulse_bits_i), .frame_sync_o(frame_sync_i));
  // 250 MHz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // Count interrupt strobes as the microcontroller would
  always @(posedge sys_clk_i)
  begin
    if (frame_done_irq_o === 1'b1) n_frame++;
    if (transfer_ready_irq_o === 1'b1) n_xfer++;
  end
  // Step n edges, then settle 1 ns past the last
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Config port write; one idle edge so writes never merge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_wr_i = 1'b1;
    cyc(1);
    cfg_wr_i = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    cfg_addr_i = a;
    cyc(2);
    cmp(cfg_rdata_o, e);
  endtask
  task automatic strobe();
    sample_strobe_i = 1'b1;
    cyc(1);
    sample_strobe_i = 1'b0;
    cyc(2);
  endtask
  // Single update, then look at both energy pins
  task automatic upd(input logic [1:0] b, input logic e6, input logic e7);
    engine_model_inst.push(b);
    engine_model_inst.stop();
    cyc(2);
    cmp(general_io_6_o, e6);
    cmp(general_io_7_o, e7);
  endtask
  task automatic end_of_test();
    $display("counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog, well beyond the 10k cycles the tests need
  initial
  begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    rst_n_i = 1'b0;
    cfg_wr_i = 1'b0;
    cfg_addr_i = 16'h0000;
    cfg_wdata_i = 8'h00;
    monitor_enable_i = 1'b0;
    pulse_polarity_invert_i = 1'b0;
    sample_strobe_i = 1'b0;
    extra_valid_i = 1'b0;
    extra_bits_i = 2'b00;
    pulse_spacing_i = 8'h00;
    pulse_width_limit_i = 8'hFF;
    equation_select_i = 3'h0;
    optical_tx_source_select_i = 2'h0;
    samples_i = {16'h0003, 16'h0006, 16'h0005, 16'h0002, 16'h0004, 16'h0008};
    mon_words_i = 128'h8000_0001_1234_5678_FFFF_0000_0F0F_F0F0;
    cyc(4);
    rst_n_i = 1'b1;
    rd(16'h2001, 8'hFF);
    wr(16'h2001, 8'h42);
    rd(16'h2001, 8'h42);
    wr(16'h2000, 8'h00);
    rd(16'h2000, 8'h00);
    rd(16'h2001, 8'h42);
    $display("register test done");
    for (int i = 0; i < 8; i++)
    begin
      equation_select_i = i[2:0];
      strobe();
      cmp(elements_o.e0, e_tab[i][0]);
      cmp(elements_o.e1, e_tab[i][1]);
      cmp(elements_o.e2, e_tab[i][2]);
    end
    // One sample per sum and two sums per interval: every other strobe ends one
    cmp(n_xfer, 4);
    $display("equation and accumulation test done");
    upd(2'b11, 1'b0, 1'b0);
    upd(2'b01, 1'b1, 1'b0);
    pulse_polarity_invert_i = 1'b1;
    upd(2'b10, 1'b1, 1'b0);
    optical_tx_source_select_i = 2'h1;
    cyc(3);
    cmp(optical_transmit_o, 1'b1);
    optical_tx_source_select_i = 2'h2;
    cyc(3);
    cmp(optical_transmit_o, 1'b0);
    extra_bits_i = 2'b10;
    extra_valid_i = 1'b1;
    cyc(1);
    extra_valid_i = 1'b0;
    cyc(2);
    cmp({general_io_8_o, general_io_9_o}, 2'b10);
    pulse_polarity_invert_i = 1'b0;
    cyc(3);
    cmp({general_io_8_o, general_io_9_o}, 2'b01);
    $display("polarity and routing test done");
    pulse_width_limit_i = 8'h01;
    upd(2'b00, 1'b1, 1'b1);
    for (int k = 0; k < 4; k++)
      upd(2'b10, k == 3, 1'b1);
    upd(2'b00, 1'b1, 1'b1);
    upd(2'b10, 1'b0, 1'b1);
    $display("width limit test done");
    pulse_width_limit_i = 8'hFF;
    pulse_spacing_i = 8'h02;
    engine_model_inst.frame();
    engine_model_inst.push(2'b11);
    engine_model_inst.push(2'b01);
    engine_model_inst.push(2'b11);
    engine_model_inst.stop();
    cyc(5);
    cmp(general_io_7_o, 1'b1);
    cyc(1);
    cmp({general_io_6_o, general_io_7_o}, 2'b00);
    cyc(7);
    cmp(general_io_6_o, 1'b0);
    cyc(1);
    cmp(general_io_6_o, 1'b1);
    engine_model_inst.frame();
    cyc(10);
    cmp(general_io_6_o, 1'b1);
    pulse_spacing_i = 8'hFF;
    engine_model_inst.frame();
    for (int k = 0; k < 8; k++)
      engine_model_inst.push(k == 7 ? 2'b10 : 2'b01);
    engine_model_inst.stop();
    cyc(1);
    cmp(pulse_ready_o, 1'b0);
    cyc(8 * 1020);
    cmp({pulse_ready_o, general_io_6_o, general_io_7_o}, 3'b101);
    $display("pulse queue test done");
    monitor_enable_i = 1'b1;
    engine_model_inst.frame();
    for (int i = 0; i < 140; i++)
    begin
      @(posedge test_clock_o);
      mon_bits[139 - i] = test_mux_output_o;
    end
    for (int w = 0; w < 4; w++)
      cmp(mon_bits[139 - 35 * w -: 35], {1'b1, mon_words_i[127 - 32 * w -: 32], 2'b00});
    cyc(8);
    cmp({test_mux_output_o, test_clock_o}, 2'b00);
    engine_model_inst.frame();
    cyc(40);
    monitor_enable_i = 1'b0;
    cyc(2);
    cmp({test_mux_output_o, test_clock_o}, 2'b00);
    cmp(n_frame, 5);
    $display("monitor and frame test done");
    end_of_test();
  end
endmodule
`default_nettype wire
